// ### sim/mrs_asserts.sv
// link checker for the rtu master and slave ends
`timescale 1ns/1ps
`default_nettype none
module mrs_asserts #(
	parameter int GAP_CYC   = 40,
	parameter int CHAR_CYC  = 8,
	parameter int BCAST_CYC = 50
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       m2s_stb,
	input  wire logic [7:0] m2s_byte,
	input  wire logic       s2m_stb,
	input  wire logic [7:0] s2m_byte,
	input  wire logic       s2m_drive
);
	logic [15:0] mg_r;
	logic [15:0] sg_r;
	logic [15:0] dc_r;
	logic [15:0] crc_r;
	logic [15:0] c;
	logic [15:0] rc_r;
	logic [15:0] rc;
	logic        bc_r;
	wire         m_first = m2s_stb && mg_r >= GAP_CYC;
	wire         s_first = s2m_stb && sg_r >= GAP_CYC;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////
	// gap counters, drive time and running query check
	always_comb begin
		c = (m_first ? 16'hFFFF : crc_r) ^ {8'h00, m2s_byte};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
	end

	// running check over the response frame, restarted at its first byte
	always_comb begin
		rc = (s_first ? 16'hFFFF : rc_r) ^ {8'h00, s2m_byte};
		for (int i = 0; i < 8; i++) begin
			rc = rc[0] ? (rc >> 1) ^ 16'hA001 : rc >> 1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mg_r  <= 16'hFFFF;
			sg_r  <= 16'hFFFF;
			dc_r  <= 16'h0000;
			crc_r <= 16'hFFFF;
			rc_r  <= 16'hFFFF;
			bc_r  <= 1'b0;
		end else begin
			mg_r  <= m2s_stb ? 16'h0000 : mg_r + {15'h0000, mg_r != 16'hFFFF};
			sg_r  <= s2m_stb ? 16'h0000 : sg_r + {15'h0000, sg_r != 16'hFFFF};
			dc_r  <= !s2m_drive ? 16'h0000 : dc_r + {15'h0000, dc_r != 16'hFFFF};
			crc_r <= m2s_stb ? c : crc_r;
			rc_r  <= s2m_stb ? rc : rc_r;
			bc_r  <= m_first ? (m2s_byte == 8'h00) : bc_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame events
	sequence s_frame_start;
		m2s_stb && mg_r >= GAP_CYC;
	endsequence

	sequence s_resp_start;
		s2m_stb && sg_r >= GAP_CYC;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	a_query_byte_gap: assert property (m2s_stb |-> mg_r >= CHAR_CYC - 1)
		else $error("query bytes closer than one character");
	a_resp_byte_gap: assert property (s2m_stb |-> sg_r >= CHAR_CYC - 1)
		else $error("response bytes closer than one character");
	a_bcast_spacing: assert property (s_frame_start |-> !bc_r || mg_r >= GAP_CYC + BCAST_CYC)
		else $error("query too soon after broadcast");
	a_bcast_silent: assert property (bc_r |-> !s2m_drive)
		else $error("slave drives after broadcast");
	a_turn_wait: assert property (s_resp_start |-> dc_r >= GAP_CYC)
		else $error("response started before silent interval");
	a_drive_covers: assert property (s2m_stb |-> s2m_drive || $past(s2m_drive))
		else $error("response byte without line driver");
	a_drive_ends: assert property ($fell(s2m_drive) |-> s2m_stb)
		else $error("driver released away from last check byte");
	a_query_crc: assert property (mg_r == GAP_CYC |-> crc_r == 16'h0000)
		else $error("query check field wrong");
	a_resp_crc: assert property (sg_r == GAP_CYC |-> rc_r == 16'h0000)
		else $error("response check field wrong");
endmodule
`default_nettype wire

// ### sim/tb.sv
// self-checking bench: master and slave ends joined across the link
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int GAP = 40;
	localparam int CHR = 8;
	localparam int GSL = 60;
	localparam int BCC = 50;
	logic        clk_i        = 1'b0;
	logic        rst_i        = 1'b1;
	logic        slow_rate_i  = 1'b0;
	logic        cmd_valid_i  = 1'b0;
	logic [7:0]  cmd_byte_i   = 8'h00;
	logic        cmd_last_i   = 1'b0;
	logic [13:0] timeout_ms_i = 14'h0000;
	logic [5:0]  qry_idx_i    = 6'h00;
	logic        rsp_valid_i  = 1'b0;
	logic [7:0]  rsp_byte_i   = 8'h00;
	logic        rsp_last_i   = 1'b0;
	wire logic   cmd_ready_o, rsp_stb_o, rsp_done_o, rsp_crc_ok_o;
	wire logic   qry_stb_o, qry_bcast_o, rsp_ready_o, alarm_o;
	wire logic [7:0] rsp_byte_o, qry_byte_o, qry_func_o;
	wire logic [5:0] qry_len_o;
	int          errors       = 0;
	int          tests_run    = 0;
	int          cyc          = 0;
	int          t0           = 0;
	logic [7:0]  rq[$];
	logic [7:0]  fr[$];

`define CHK(what, exp, got) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("BAD %s expected %h seen %h", what, exp, got); \
	end \
end

	mrs_if lnk();
	mrs_master #(.GAP_CYC(GAP), .GAP_SLOW_CYC(GSL), .BCAST_CYC(BCC), .CHAR_CYC(CHR)) i_mrs_master (
		.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk.master), .slow_rate_i(slow_rate_i),
		.cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .cmd_last_i(cmd_last_i),
		.cmd_ready_o(cmd_ready_o), .rsp_stb_o(rsp_stb_o), .rsp_byte_o(rsp_byte_o),
		.rsp_done_o(rsp_done_o), .rsp_crc_ok_o(rsp_crc_ok_o));
	mrs_slave #(.GAP_CYC(GAP), .CHAR_CYC(CHR)) i_mrs_slave (
		.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk.slave), .own_addr_i(8'h05),
		.timeout_ms_i(timeout_ms_i), .tx_wait_i(14'h0001), .qry_idx_i(qry_idx_i),
		.qry_byte_o(qry_byte_o), .qry_stb_o(qry_stb_o), .qry_bcast_o(qry_bcast_o),
		.qry_func_o(qry_func_o), .qry_len_o(qry_len_o), .rsp_valid_i(rsp_valid_i),
		.rsp_byte_i(rsp_byte_i), .rsp_last_i(rsp_last_i), .rsp_ready_o(rsp_ready_o),
		.alarm_o(alarm_o));
	mrs_asserts #(.GAP_CYC(GAP), .CHAR_CYC(CHR), .BCAST_CYC(BCC)) i_mrs_asserts (
		.clk_i(clk_i), .rst_i(rst_i), .m2s_stb(lnk.m2s_stb), .m2s_byte(lnk.m2s_byte),
		.s2m_stb(lnk.s2m_stb), .s2m_byte(lnk.s2m_byte), .s2m_drive(lnk.s2m_drive));

	always #25 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			end_sim();
		end
	end

	always @(negedge clk_i) begin
		if (rsp_stb_o === 1'b1) begin
			rq.push_back(rsp_byte_o);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] r;
		r = 16'hFFFF;
		foreach (q[k]) begin
			r = r ^ {8'h00, q[k]};
			for (int i = 0; i < 8; i++) begin
				r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
			end
		end
		return r;
	endfunction

	task automatic send(input logic [7:0] q[$]);
		foreach (q[k]) begin
			cmd_valid_i = 1'b1;
			cmd_byte_i  = q[k];
			cmd_last_i  = (k == q.size() - 1);
			while (cmd_ready_o !== 1'b1) @(negedge clk_i);
			@(negedge clk_i);
		end
		cmd_valid_i = 1'b0;
		cmd_last_i  = 1'b0;
	endtask

	task automatic resp(input logic [7:0] q[$]);
		foreach (q[k]) begin
			rsp_valid_i = 1'b1;
			rsp_byte_i  = q[k];
			rsp_last_i  = (k == q.size() - 1);
			while (rsp_ready_o !== 1'b1) @(negedge clk_i);
			@(negedge clk_i);
		end
		rsp_valid_i = 1'b0;
		rsp_last_i  = 1'b0;
	endtask

	task automatic wait_qry(output bit seen);
		seen = 1'b0;
		repeat (GAP + 4 * CHR + 20) begin
			@(negedge clk_i);
			if (qry_stb_o === 1'b1) begin
				seen = 1'b1;
				t0   = cyc;
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_unicast(input logic [7:0] fn);
		bit          seen;
		logic [15:0] c;
		fr = '{8'h05, fn, 8'h00, 8'h01, 8'h00, 8'h02};
		send(fr);
		wait_qry(seen);
		`CHK("accept", 1'b1, seen)
		`CHK("func", fn, qry_func_o)
		`CHK("len", 6'h08, qry_len_o)
		`CHK("bcast", 1'b0, qry_bcast_o)
		c = crc(fr);
		fr.push_back(c[7:0]);
		fr.push_back(c[15:8]);
		for (int k = 0; k < 8; k++) begin
			qry_idx_i = 6'(k);
			@(negedge clk_i);
			`CHK("qbyte", fr[k], qry_byte_o)
		end
		while (rsp_ready_o !== 1'b1) @(negedge clk_i);
		`CHK("turn", 1'b1, (cyc - t0 >= GAP + 2000) && (cyc - t0 <= GAP + 2006))
		rq.delete();
		resp(fr[0:5]);
		while (rsp_done_o !== 1'b1) @(negedge clk_i);
		`CHK("crc ok", 1'b1, rsp_crc_ok_o)
		`CHK("rsp len", 8, rq.size())
		for (int k = 0; k < 8; k++) begin
			`CHK("rbyte", fr[k], rq[k])
		end
	endtask

	task automatic t_bcast;
		bit   seen;
		logic drv;
		fr = '{8'h00, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'hAB, 8'hCD};
		send(fr);
		wait_qry(seen);
		`CHK("accept", 1'b1, seen)
		`CHK("func", 8'h10, qry_func_o)
		`CHK("len", 6'h0B, qry_len_o)
		`CHK("bcast", 1'b1, qry_bcast_o)
		drv = 1'b0;
		repeat (2100) begin
			@(negedge clk_i);
			drv = drv | lnk.s2m_drive;
		end
		`CHK("silent", 1'b0, drv)
	endtask

	task automatic t_refused;
		bit          seen;
		logic [15:0] tbl[5] = '{16'h0003, 16'h0008, 16'h0906, 16'h0507, 16'h0510};
		slow_rate_i = 1'b1;
		foreach (tbl[k]) begin
			fr = '{tbl[k][15:8], tbl[k][7:0], 8'h00, 8'h01, 8'h00, 8'h02};
			send(fr);
			wait_qry(seen);
			`CHK("refuse", 1'b0, seen)
		end
		slow_rate_i = 1'b0;
	endtask

	// spacing after a query: fast gap, slow gap, then broadcast extra time
	task automatic t_spacing;
		int n;
		int g;
		fr = '{8'h02, 8'h07};
		`CHK("crc ref", 16'h1241, crc(fr))
		for (int s = 0; s < 3; s++) begin
			g = (s == 1) ? GSL : ((s == 2) ? GAP + BCC : GAP);
			slow_rate_i = (s == 1);
			fr = '{(s == 2) ? 8'h00 : 8'h09, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02};
			send(fr);
			n = 0;
			while (cmd_ready_o !== 1'b1) begin
				@(negedge clk_i);
				n++;
			end
			`CHK("space", 1'b1, (n >= 2 * CHR + g) && (n <= 3 * CHR + g + 4))
		end
		slow_rate_i = 1'b0;
	endtask

	task automatic t_timeout;
		bit seen;
		repeat (21000) @(negedge clk_i);
		`CHK("alarm off", 1'b0, alarm_o)
		timeout_ms_i = 14'h0001;
		fr = '{8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02};
		send(fr);
		wait_qry(seen);
		`CHK("accept", 1'b1, seen)
		repeat (17500) @(negedge clk_i);
		`CHK("alarm early", 1'b0, alarm_o)
		repeat (3000) @(negedge clk_i);
		`CHK("alarm", 1'b1, alarm_o)
		send(fr);
		wait_qry(seen);
		`CHK("alarm clear", 1'b0, alarm_o)
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		t_unicast(8'h06);
		t_unicast(8'h03);
		t_unicast(8'h08);
		t_bcast();
		t_refused();
		t_spacing();
		t_timeout();
		end_sim();
	end
endmodule
`default_nettype wire

// ### src/mrs_if.sv
// byte-level link between the rtu master end and the slave end
`timescale 1ns/1ps
`default_nettype none
interface mrs_if;
	logic       m2s_stb;
	logic [7:0] m2s_byte;
	logic       s2m_stb;
	logic [7:0] s2m_byte;
	logic       s2m_drive;
	modport slave  (input m2s_stb, input m2s_byte, output s2m_stb, output s2m_byte, output s2m_drive);
	modport master (output m2s_stb, output m2s_byte, input s2m_stb, input s2m_byte, input s2m_drive);
endinterface
`default_nettype wire

// ### src/mrs_master.sv
// master end: query send with crc, frame spacing, response collection
`timescale 1ns/1ps
`default_nettype none
module mrs_master
	import mrs_pkg::*;
#(
	parameter int GAP_CYC      = GAP_CYCLES,
	parameter int GAP_SLOW_CYC = GAP_SLOW_CYCLES,
	parameter int BCAST_CYC    = BCAST_CYCLES,
	parameter int CHAR_CYC     = CHAR_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	mrs_if.master           lnk,
	input  wire logic       slow_rate_i,
	input  wire logic       cmd_valid_i,
	input  wire logic [7:0] cmd_byte_i,
	input  wire logic       cmd_last_i,
	output logic            cmd_ready_o,
	output logic            rsp_stb_o,
	output logic [7:0]      rsp_byte_o,
	output logic            rsp_done_o,
	output logic            rsp_crc_ok_o
);
	mrs_mst_e    st_r;
	logic [CW-1:0] chr_r;
	logic [CW-1:0] cnt_r;
	logic [15:0] crc_r;
	logic        first_r;
	logic        bc_r;
	logic        rdy_r;
	logic        stb_r;
	logic [7:0]  byte_r;
	logic [15:0] rcrc_r;
	logic [8:0]  rlen_r;
	logic        ract_r;
	logic [CW-1:0] rgap_r;
	logic        rstb_r;
	logic [7:0]  rbyte_r;
	logic        rdone_r;
	logic        rok_r;

	////////////////////////////////////////////////////////////////////////
	wire          chr0_w  = (chr_r == '0);
	wire          take_w  = rdy_r && cmd_valid_i;
	wire [CW-1:0] gapc_w  = slow_rate_i ? CW'(GAP_SLOW_CYC) : CW'(GAP_CYC);
	wire [CW-1:0] space_w = CW'(CHAR_CYC) + gapc_w + (bc_r ? CW'(BCAST_CYC) : '0);
	wire          rend_w  = ract_r && (rgap_r == CW'(GAP_CYC));

	////////////////////////////////////////////////////////////////////////
	// query transmit
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r    <= MS_DATA;
			chr_r   <= '0;
			cnt_r   <= '0;
			crc_r   <= CRC_INIT;
			first_r <= 1'b1;
			bc_r    <= 1'b0;
			rdy_r   <= 1'b0;
			stb_r   <= 1'b0;
			byte_r  <= 8'h00;
		end else begin
			stb_r <= 1'b0;
			if (!chr0_w) begin
				chr_r <= chr_r - 1'b1;
			end
			case (st_r)
				MS_DATA: begin
					if (take_w) begin
						rdy_r   <= 1'b0;
						stb_r   <= 1'b1;
						byte_r  <= cmd_byte_i;
						crc_r   <= mrs_crc_upd(crc_r, cmd_byte_i);
						chr_r   <= CW'(CHAR_CYC - 1);
						first_r <= 1'b0;
						if (first_r) begin
							bc_r <= (cmd_byte_i == BCAST_ADDR);
						end
						if (cmd_last_i) begin
							st_r <= MS_CRCL;
						end
					end else if (chr0_w) begin
						rdy_r <= 1'b1;
					end
				end
				MS_CRCL: begin
					if (chr0_w) begin
						stb_r  <= 1'b1;
						byte_r <= crc_r[7:0];
						chr_r  <= CW'(CHAR_CYC - 1);
						st_r   <= MS_CRCH;
					end
				end
				MS_CRCH: begin
					if (chr0_w) begin
						stb_r  <= 1'b1;
						byte_r <= crc_r[15:8];
						cnt_r  <= '0;
						st_r   <= MS_SPACE;
					end
				end
				MS_SPACE: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r >= space_w) begin
						st_r    <= MS_DATA;
						crc_r   <= CRC_INIT;
						first_r <= 1'b1;
						chr_r   <= '0;
					end
				end
				default: begin
					st_r <= MS_DATA;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// response collection; crc over the whole frame leaves zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rcrc_r  <= CRC_INIT;
			rlen_r  <= '0;
			ract_r  <= 1'b0;
			rgap_r  <= '0;
			rstb_r  <= 1'b0;
			rbyte_r <= 8'h00;
			rdone_r <= 1'b0;
			rok_r   <= 1'b0;
		end else begin
			rstb_r  <= lnk.s2m_stb;
			rdone_r <= rend_w;
			if (lnk.s2m_stb) begin
				rbyte_r <= lnk.s2m_byte;
				rcrc_r  <= mrs_crc_upd(rcrc_r, lnk.s2m_byte);
				rlen_r  <= (rlen_r == 9'h1FF) ? rlen_r : rlen_r + 9'h001;
				ract_r  <= 1'b1;
				rgap_r  <= '0;
			end else begin
				rgap_r <= (rgap_r == CW'(GAP_CYC)) ? rgap_r : rgap_r + 1'b1;
				if (rend_w) begin
					rok_r  <= (rcrc_r == 16'h0000) && (rlen_r >= 9'(MIN_FRAME));
					rcrc_r <= CRC_INIT;
					rlen_r <= '0;
					ract_r <= 1'b0;
				end
			end
		end
	end

	assign lnk.m2s_stb  = stb_r;
	assign lnk.m2s_byte = byte_r;
	assign cmd_ready_o  = rdy_r;
	assign rsp_stb_o    = rstb_r;
	assign rsp_byte_o   = rbyte_r;
	assign rsp_done_o   = rdone_r;
	assign rsp_crc_ok_o = rok_r;
endmodule
`default_nettype wire

// ### src/mrs_pkg.sv
// shared constants, state types and crc helper for the rtu framing ends
package mrs_pkg;
	localparam int CLK_HZ          = 20_000_000;
	localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
	// times in their own units
	localparam int IDLE_GAP_US     = 3500;
	localparam int IDLE_GAP_SLOW_US = 5500;
	localparam int BCAST_EXTRA_US  = 5000;
	localparam int CHAR_TIME_NS    = 286459;
	localparam int WAIT_UNIT_US    = 100;
	// derived cycle counts; least times round up
	localparam int GAP_CYCLES      = IDLE_GAP_US * CLK_PER_US;
	localparam int GAP_SLOW_CYCLES = IDLE_GAP_SLOW_US * CLK_PER_US;
	localparam int BCAST_CYCLES    = BCAST_EXTRA_US * CLK_PER_US;
	localparam int CHAR_CYCLES     = (CHAR_TIME_NS * CLK_PER_US + 999) / 1000;
	localparam int TICK_CYCLES     = WAIT_UNIT_US * CLK_PER_US;
	localparam int TICKS_PER_MS    = 1000 / WAIT_UNIT_US;
	// setting ranges and defaults
	localparam int TIMEOUT_MAX_MS  = 10000;
	localparam int TIMEOUT_DEF_MS  = 0;
	localparam int WAIT_MAX        = 10000;
	localparam int WAIT_DEF        = 100;
	// counter widths
	localparam int CW              = 25;
	localparam int TW              = 18;
	// frame layout
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [7:0] FN_READ    = 8'h03;
	localparam logic [7:0] FN_WRITE1  = 8'h06;
	localparam logic [7:0] FN_DIAG    = 8'h08;
	localparam logic [7:0] FN_WRITEN  = 8'h10;
	localparam int QRY_FIX         = 8;
	localparam int MULTI_MIN       = 11;
	localparam int QRY_MAX         = 41;
	localparam int MIN_FRAME       = 4;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;

	typedef enum logic [4:0] {
		SL_IDLE = 5'b00001,
		SL_TURN = 5'b00010,
		SL_DATA = 5'b00100,
		SL_CRCL = 5'b01000,
		SL_CRCH = 5'b10000
	} mrs_sst_e;

	typedef enum logic [3:0] {
		MS_DATA  = 4'b0001,
		MS_CRCL  = 4'b0010,
		MS_CRCH  = 4'b0100,
		MS_SPACE = 4'b1000
	} mrs_mst_e;

	function automatic logic [15:0] mrs_crc_upd(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage

// ### src/mrs_slave.sv
// slave end: query framing, crc check, turnaround, response send, timeout alarm
// How it works
// - own address query gets executed and answered
// - address zero executes, never answers
// - alarm when no accepted query (own address or broadcast) within timeout
// - timeout 0..10000 ms, zero disables
// - drive on, wait gap plus wait time
// - wait time in 0.1 ms units
// - master spaces broadcasts gap plus 5 ms
// - master idles one character plus gap between frames
// - master gap 5.5 ms slow, 3.5 fast
// - address, function, data, 16-bit check
// - 03h read, 8-byte query, no broadcast
// - 06h write one, 8 bytes, broadcastable
// - 10h write many, 11..41 bytes, broadcastable
// - 08h diagnosis, 8 bytes; only four codes, but any sub-code is accepted
// - crc must match check field to accept
// - crc from FFFFh, shift right, xor A001h
// - crc covers address through last data
// - response has same layout plus crc
// - other addresses ignored silently
`timescale 1ns/1ps
`default_nettype none
module mrs_slave
	import mrs_pkg::*;
#(
	parameter int GAP_CYC  = GAP_CYCLES,
	parameter int CHAR_CYC = CHAR_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	mrs_if.slave             lnk,
	input  wire logic [7:0]  own_addr_i,
	input  wire logic [13:0] timeout_ms_i,
	input  wire logic [13:0] tx_wait_i,
	input  wire logic [5:0]  qry_idx_i,
	output logic [7:0]       qry_byte_o,
	output logic             qry_stb_o,
	output logic             qry_bcast_o,
	output logic [7:0]       qry_func_o,
	output logic [5:0]       qry_len_o,
	input  wire logic        rsp_valid_i,
	input  wire logic [7:0]  rsp_byte_i,
	input  wire logic        rsp_last_i,
	output logic             rsp_ready_o,
	output logic             alarm_o
);
	mrs_sst_e    st_r;
	logic [7:0]  qbuf_r [QRY_MAX];
	logic [8:0]  len_r;
	logic        frm_r;
	logic [CW-1:0] gap_r;
	logic [15:0] crc_r;
	logic [15:0] crc_p1_r;
	logic [15:0] crc_p2_r;
	logic [7:0]  b0_r;
	logic [7:0]  b1_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] chr_r;
	logic [15:0] tcrc_r;
	logic        rdy_r;
	logic        stb_r;
	logic [7:0]  byte_r;
	logic        drive_r;
	logic        qstb_r;
	logic        qbc_r;
	logic [7:0]  qfn_r;
	logic [5:0]  qlen_r;
	logic [7:0]  qbyte_r;
	logic [CW-1:0] div_r;
	logic [TW-1:0] to_r;
	logic        alarm_r;

	////////////////////////////////////////////////////////////////////////
	// decode of the finished frame
	wire         rx_take  = lnk.m2s_stb && (st_r == SL_IDLE);
	wire         eof_w    = frm_r && (gap_r == CW'(GAP_CYC));
	wire [7:0]   adr_w    = qbuf_r[0];
	wire [7:0]   fn_w     = qbuf_r[1];
	wire         crc_ok_w = (len_r >= 9'(MIN_FRAME)) && (crc_p2_r == {b1_r, b0_r});
	wire         fix_w    = (fn_w == FN_READ) || (fn_w == FN_WRITE1) || (fn_w == FN_DIAG);
	wire         multi_w  = (fn_w == FN_WRITEN) && (len_r >= 9'(MULTI_MIN))
	                        && (len_r <= 9'(QRY_MAX));
	wire         len_ok_w = (fix_w && (len_r == 9'(QRY_FIX))) || multi_w;
	wire         bc_w     = (adr_w == BCAST_ADDR);
	wire         mine_w   = (own_addr_i != BCAST_ADDR) && (adr_w == own_addr_i);
	wire         bc_ok_w  = (fn_w == FN_WRITE1) || (fn_w == FN_WRITEN);
	wire         acc_w    = eof_w && crc_ok_w && len_ok_w && (mine_w || (bc_w && bc_ok_w));
	wire [CW-1:0] tgt_w   = CW'(GAP_CYC) + CW'(tx_wait_i) * CW'(TICK_CYCLES);
	wire         chr0_w   = (chr_r == '0);
	wire         take_w   = rdy_r && rsp_valid_i;
	wire         tick_w   = (div_r == CW'(TICK_CYCLES - 1));
	wire [TW-1:0] to_lim_w = TW'(timeout_ms_i) * TW'(TICKS_PER_MS);

	////////////////////////////////////////////////////////////////////////
	// receive side
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gap_r <= '0;
			frm_r <= 1'b0;
			len_r <= '0;
		end else if (rx_take) begin
			gap_r <= '0;
			frm_r <= 1'b1;
			len_r <= (len_r == 9'h1FF) ? len_r : len_r + 9'h001;
		end else begin
			gap_r <= (gap_r == CW'(GAP_CYC)) ? gap_r : gap_r + 1'b1;
			if (eof_w) begin
				frm_r <= 1'b0;
				len_r <= '0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			crc_r    <= CRC_INIT;
			crc_p1_r <= CRC_INIT;
			crc_p2_r <= CRC_INIT;
			b0_r     <= 8'h00;
			b1_r     <= 8'h00;
		end else if (rx_take) begin
			crc_r    <= mrs_crc_upd(crc_r, lnk.m2s_byte);
			crc_p1_r <= crc_r;
			crc_p2_r <= crc_p1_r;
			b0_r     <= b1_r;
			b1_r     <= lnk.m2s_byte;
		end else if (eof_w) begin
			crc_r    <= CRC_INIT;
			crc_p1_r <= CRC_INIT;
			crc_p2_r <= CRC_INIT;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rx_take && (len_r < 9'(QRY_MAX))) begin
			qbuf_r[len_r[5:0]] <= lnk.m2s_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// hand-off of an accepted query to the user side
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			qstb_r  <= 1'b0;
			qbc_r   <= 1'b0;
			qfn_r   <= 8'h00;
			qlen_r  <= 6'h00;
			qbyte_r <= 8'h00;
		end else begin
			qstb_r  <= acc_w;
			qbyte_r <= (qry_idx_i < 6'(QRY_MAX)) ? qbuf_r[qry_idx_i] : 8'h00;
			if (acc_w) begin
				qbc_r  <= bc_w;
				qfn_r  <= fn_w;
				qlen_r <= len_r[5:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// turnaround and response transmit
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r    <= SL_IDLE;
			cnt_r   <= '0;
			chr_r   <= '0;
			tcrc_r  <= CRC_INIT;
			rdy_r   <= 1'b0;
			stb_r   <= 1'b0;
			byte_r  <= 8'h00;
			drive_r <= 1'b0;
		end else begin
			stb_r <= 1'b0;
			if (!chr0_w) begin
				chr_r <= chr_r - 1'b1;
			end
			case (st_r)
				SL_IDLE: begin
					if (acc_w && mine_w) begin
						st_r    <= SL_TURN;
						drive_r <= 1'b1;
						cnt_r   <= '0;
					end
				end
				SL_TURN: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r >= tgt_w) begin
						st_r   <= SL_DATA;
						tcrc_r <= CRC_INIT;
						chr_r  <= '0;
					end
				end
				SL_DATA: begin
					if (take_w) begin
						rdy_r  <= 1'b0;
						stb_r  <= 1'b1;
						byte_r <= rsp_byte_i;
						tcrc_r <= mrs_crc_upd(tcrc_r, rsp_byte_i);
						chr_r  <= CW'(CHAR_CYC - 1);
						if (rsp_last_i) begin
							st_r <= SL_CRCL;
						end
					end else if (chr0_w) begin
						rdy_r <= 1'b1;
					end
				end
				SL_CRCL: begin
					if (chr0_w) begin
						stb_r  <= 1'b1;
						byte_r <= tcrc_r[7:0];
						chr_r  <= CW'(CHAR_CYC - 1);
						st_r   <= SL_CRCH;
					end
				end
				SL_CRCH: begin
					if (chr0_w && drive_r && !stb_r && (byte_r == tcrc_r[7:0])) begin
						stb_r   <= 1'b1;
						byte_r  <= tcrc_r[15:8];
						chr_r   <= CW'(CHAR_CYC - 1);
						drive_r <= 1'b0;
					end else if (chr0_w && !drive_r) begin
						st_r <= SL_IDLE;
					end
				end
				default: begin
					st_r <= SL_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// accepted-query timeout alarm on a 0.1 ms tick
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_r   <= '0;
			to_r    <= '0;
			alarm_r <= 1'b0;
		end else begin
			div_r <= tick_w ? '0 : div_r + 1'b1;
			if (acc_w) begin
				to_r <= '0;
			end else if (tick_w && (to_r != {TW{1'b1}})) begin
				to_r <= to_r + 1'b1;
			end
			alarm_r <= (timeout_ms_i != 14'h0000) && (to_r >= to_lim_w);
		end
	end

	assign lnk.s2m_stb   = stb_r;
	assign lnk.s2m_byte  = byte_r;
	assign lnk.s2m_drive = drive_r;
	assign qry_byte_o    = qbyte_r;
	assign qry_stb_o     = qstb_r;
	assign qry_bcast_o   = qbc_r;
	assign qry_func_o    = qfn_r;
	assign qry_len_o     = qlen_r;
	assign rsp_ready_o   = rdy_r;
	assign alarm_o       = alarm_r;
endmodule
`default_nettype wire
